//--- core/pio_params.svh
// constants of the port and pull-up control block
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

// ----------------------------------------
// port widths
// ----------------------------------------
`define PIO_P0_W 4
`define PIO_P1_W 2
`define PIO_P2_W 6
`define PIO_P5_W 4
`define PIO_P6_W 4
`define PIO_BYTE_W 8

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PIO_ADDR_P0_DIR 16'hFF20
`define PIO_ADDR_P1_DIR 16'hFF21
`define PIO_ADDR_P2_DIR 16'hFF22
`define PIO_ADDR_P5_DIR 16'hFF25
`define PIO_ADDR_P2_PUP 16'hFF32
`define PIO_ADDR_SH_PUP 16'hFFF7
`define PIO_ADDR_P0_DAT 16'hFF00
`define PIO_ADDR_P1_DAT 16'hFF01
`define PIO_ADDR_P2_DAT 16'hFF02
`define PIO_ADDR_P5_DAT 16'hFF05
`define PIO_ADDR_P6_DAT 16'hFF06

// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define PIO_DIR_RST 8'hFF
`define PIO_PUP_RST 8'h00
`define PIO_LATCH_RST 8'h00
`define PIO_UNMAPPED_RD 8'h00
`define PIO_SH_PUP_P0_BIT 0
`define PIO_SH_PUP_P1_BIT 1
`define PIO_IRQ_LO_BIT 3
`define PIO_IRQ_HI_BIT 5

`endif

//--- core/pio_pkg.sv
// types and shared functions of the port and pull-up control block
package pio_pkg;

    // ----------------------------------------
    // cpu access to the port registers
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } pio_bus_req_t;

    // byte write replaces all, bit write replaces wdata[0] at bit_sel
    function automatic logic [7:0] pio_merge(input logic [7:0] old,
                                             input logic bit_op,
                                             input logic [2:0] sel,
                                             input logic [7:0] wdata);
        logic [7:0] r;
        r = old;
        if (bit_op) begin
            r[sel] = wdata[0];
        end else begin
            r = wdata;
        end
        return r;
    endfunction

endpackage

//--- core/pio_port_slice.sv
// one digital port: output latch, drive value and read-back value
`include "pio_params.svh"

module pio_port_slice #(
    parameter int W = 4,
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_i,
    input wire logic bit_op_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [7:0] wdata_i,
    input wire logic [W-1:0] dir_i,
    input wire logic [W-1:0] alt_out_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] read_o,
    output logic [W-1:0] drive_o,
    output logic [W-1:0] drive_en_o
);

    logic [W-1:0] latch;
    logic [7:0] latch_byte;
    logic [7:0] next_byte;
    logic [W-1:0] level;

    // ----------------------------------------
    // latch update
    // ----------------------------------------
    assign latch_byte = {{(8 - W){1'b0}}, latch};
    assign next_byte = pio_pkg::pio_merge(latch_byte, bit_op_i, bit_sel_i, wdata_i);

    // RQ20 latch only on write
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            latch <= W'(`PIO_LATCH_RST);
        end else if (wr_i) begin
            latch <= next_byte[W-1:0];
        end
    end

    // ----------------------------------------
    // pin drive and read-back
    // ----------------------------------------
    // alternate outputs need latch 0 so they can pass through the or
    assign level = latch | alt_out_i;
    // RQ9 zero enables buffer
    assign drive_o = OPEN_DRAIN ? '0 : level;
    // open drain only sinks, so a one leaves the pin released
    assign drive_en_o = OPEN_DRAIN ? (~dir_i & ~level) : ~dir_i;
    // RQ21 latch or pin
    assign read_o = (~dir_i & latch) | (dir_i & pin_i);

endmodule

//--- core/pio_top.sv
// port i/o and pull-up control block: registers, pins, pull-ups, events
//
// Notes on behaviour
// RQ1: two-bit port with output latch and per-bit direction bits.
// RQ2: one shared bit enables both two-bit port pull-ups, input pins only.
// RQ3: six-bit port with latches, per-bit direction, alternate functions.
// RQ4: each six-bit port pull-up bit connects its pull-up regardless of direction.
// RQ5: four-bit open-drain port with latches and per-pin direction.
// RQ6: four-bit input-only port, no latch, no direction, also analog inputs.
// RQ7: reset places every port in input mode, all buffers off.
// RQ8: direction registers reset to all ones; bit or byte writes each.
// RQ9: direction zero enables output buffer, one disables it.
// RQ10: direction registers take single-bit and full byte writes.
// RQ11: software sets direction and latch to suit alternate functions.
// RQ12: output level change on interrupt pins raises the interrupt request.
// RQ13: software masks the interrupt before using six-bit port outputs.
// RQ14: shared pull-ups only on input bits, never on output bits.
// RQ15: shared pull-up register resets to zero; bit or byte writes.
// RQ16: shared bit 0 serves the four-bit port, bit 1 the two-bit port.
// RQ17: six-bit pull-up register resets to zero; bit n serves pin n.
// RQ18: six-bit pull-up register takes single-bit and byte writes.
// RQ19: software reads the open-drain port three times on some parts.
// RQ20: write in input mode changes only the latch, never the pin.
// RQ21: read returns latch in output mode, pin in input mode.
// RQ22: unused direction bits read one; unused pull-up bits read zero.
// RQ23: every pull-up enable is a per-pin digital output.
`include "pio_params.svh"

module pio_top #(
    parameter int P0_W = `PIO_P0_W,
    parameter int P1_W = `PIO_P1_W,
    parameter int P2_W = `PIO_P2_W,
    parameter int P5_W = `PIO_P5_W,
    parameter int P6_W = `PIO_P6_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire pio_pkg::pio_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic [P0_W-1:0] p0_pin_i,
    output logic [P0_W-1:0] p0_out_o,
    output logic [P0_W-1:0] p0_oe_n_o,
    output logic [P0_W-1:0] p0_pullup_o,
    input wire logic [P1_W-1:0] p1_pin_i,
    output logic [P1_W-1:0] p1_out_o,
    output logic [P1_W-1:0] p1_oe_n_o,
    output logic [P1_W-1:0] p1_pullup_o,
    input wire logic [P2_W-1:0] p2_pin_i,
    input wire logic [P2_W-1:0] p2_alt_out_i,
    output logic [P2_W-1:0] p2_out_o,
    output logic [P2_W-1:0] p2_oe_n_o,
    output logic [P2_W-1:0] p2_pullup_o,
    input wire logic [P5_W-1:0] p5_pin_i,
    output logic [P5_W-1:0] p5_out_o,
    output logic [P5_W-1:0] p5_oe_n_o,
    input wire logic [P6_W-1:0] p6_pin_i,
    output logic [2:0] ext_irq_req_o
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [7:0] port0_direction;
    logic [7:0] port1_direction;
    logic [7:0] port2_direction;
    logic [7:0] port5_direction;
    logic [7:0] port2_pullup_enable;
    logic [7:0] shared_pullup_option;
    logic sel_p0_dir;
    logic sel_p1_dir;
    logic sel_p2_dir;
    logic sel_p5_dir;
    logic sel_p2_pup;
    logic sel_sh_pup;
    logic sel_p0_dat;
    logic sel_p1_dat;
    logic sel_p2_dat;
    logic sel_p5_dat;
    logic sel_p6_dat;

    logic wr_p0_dir;
    logic wr_p1_dir;
    logic wr_p2_dir;
    logic wr_p5_dir;
    logic wr_p2_pup;
    logic wr_sh_pup;
    logic [7:0] merged;
    logic [7:0] next_rdata;
    logic [P0_W-1:0] p0_read;
    logic [P0_W-1:0] p0_drive;
    logic [P0_W-1:0] p0_drive_en;
    logic [P1_W-1:0] p1_read;
    logic [P1_W-1:0] p1_drive;
    logic [P1_W-1:0] p1_drive_en;
    logic [P2_W-1:0] p2_read;
    logic [P2_W-1:0] p2_drive;
    logic [P2_W-1:0] p2_drive_en;
    logic [P5_W-1:0] p5_read;
    logic [P5_W-1:0] p5_drive;
    logic [P5_W-1:0] p5_drive_en;
    logic [P0_W-1:0] next_p0_pullup;
    logic [P1_W-1:0] next_p1_pullup;
    logic [P2_W-1:0] next_p2_pullup;
    logic [2:0] irq_level;
    logic [2:0] irq_level_prev;
    logic irq_armed;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    assign sel_p0_dir = (bus_i.addr == `PIO_ADDR_P0_DIR);
    assign sel_p1_dir = (bus_i.addr == `PIO_ADDR_P1_DIR);
    assign sel_p2_dir = (bus_i.addr == `PIO_ADDR_P2_DIR);
    assign sel_p5_dir = (bus_i.addr == `PIO_ADDR_P5_DIR);
    assign sel_p2_pup = (bus_i.addr == `PIO_ADDR_P2_PUP);
    assign sel_sh_pup = (bus_i.addr == `PIO_ADDR_SH_PUP);
    assign sel_p0_dat = (bus_i.addr == `PIO_ADDR_P0_DAT);
    assign sel_p1_dat = (bus_i.addr == `PIO_ADDR_P1_DAT);
    assign sel_p2_dat = (bus_i.addr == `PIO_ADDR_P2_DAT);
    assign sel_p5_dat = (bus_i.addr == `PIO_ADDR_P5_DAT);
    assign sel_p6_dat = (bus_i.addr == `PIO_ADDR_P6_DAT);

    // write strobes; each register decodes on its own address only
    assign wr_p0_dir = bus_i.wr & sel_p0_dir;
    assign wr_p1_dir = bus_i.wr & sel_p1_dir;
    assign wr_p2_dir = bus_i.wr & sel_p2_dir;
    assign wr_p5_dir = bus_i.wr & sel_p5_dir;
    assign wr_p2_pup = bus_i.wr & sel_p2_pup;
    assign wr_sh_pup = bus_i.wr & sel_sh_pup;

    // ----------------------------------------
    // direction registers
    // ----------------------------------------
    // RQ10 bit or byte
    function automatic logic [7:0] dir_write(input logic [7:0] old,
                                             input int width,
                                             input pio_pkg::pio_bus_req_t req);
        logic [7:0] m;
        logic [7:0] keep;
        m = pio_pkg::pio_merge(old, req.bit_op, req.bit_sel, req.wdata);
        keep = `PIO_DIR_RST << width;
        return m | keep;
    endfunction

    // RQ8 reset to ones
    // RQ7 all inputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            port0_direction <= `PIO_DIR_RST;
            port1_direction <= `PIO_DIR_RST;
            port2_direction <= `PIO_DIR_RST;
            port5_direction <= `PIO_DIR_RST;
        end else begin
            if (wr_p0_dir) begin
                port0_direction <= dir_write(port0_direction, P0_W, bus_i);
            end
            if (wr_p1_dir) begin
                port1_direction <= dir_write(port1_direction, P1_W, bus_i);
            end
            if (wr_p2_dir) begin
                port2_direction <= dir_write(port2_direction, P2_W, bus_i);
            end
            if (wr_p5_dir) begin
                port5_direction <= dir_write(port5_direction, P5_W, bus_i);
            end
        end
    end

    // ----------------------------------------
    // pull-up registers
    // ----------------------------------------
    // unused bits are masked so they always read zero
    assign merged = pio_pkg::pio_merge(sel_p2_pup ? port2_pullup_enable
                                                  : shared_pullup_option,
                                       bus_i.bit_op, bus_i.bit_sel, bus_i.wdata);

    // RQ15 shared reset
    // RQ18 bit or byte
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            port2_pullup_enable <= `PIO_PUP_RST;
            shared_pullup_option <= `PIO_PUP_RST;
        end else begin
            // RQ17 pin mapping
            if (wr_p2_pup) begin
                port2_pullup_enable <= merged & ~(`PIO_DIR_RST << P2_W);
            end
            // RQ22 unused bits zero
            if (wr_sh_pup) begin
                shared_pullup_option <= merged & 8'h03;
            end
        end
    end

    // ----------------------------------------
    // port slices
    // ----------------------------------------
    // RQ1 two-bit port
    pio_port_slice #(.W(P1_W), .OPEN_DRAIN(1'b0)) u_p1 (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bus_i.wr & sel_p1_dat),
        .bit_op_i(bus_i.bit_op),
        .bit_sel_i(bus_i.bit_sel),
        .wdata_i(bus_i.wdata),
        .dir_i(port1_direction[P1_W-1:0]),
        .alt_out_i('0),
        .pin_i(p1_pin_i),
        .read_o(p1_read),
        .drive_o(p1_drive),
        .drive_en_o(p1_drive_en)
    );

    // four-bit general port
    pio_port_slice #(.W(P0_W), .OPEN_DRAIN(1'b0)) u_p0 (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bus_i.wr & sel_p0_dat),
        .bit_op_i(bus_i.bit_op),
        .bit_sel_i(bus_i.bit_sel),
        .wdata_i(bus_i.wdata),
        .dir_i(port0_direction[P0_W-1:0]),
        .alt_out_i('0),
        .pin_i(p0_pin_i),
        .read_o(p0_read),
        .drive_o(p0_drive),
        .drive_en_o(p0_drive_en)
    );

    // RQ3 six-bit port
    // RQ11 alternate outputs
    pio_port_slice #(.W(P2_W), .OPEN_DRAIN(1'b0)) u_p2 (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bus_i.wr & sel_p2_dat),
        .bit_op_i(bus_i.bit_op),
        .bit_sel_i(bus_i.bit_sel),
        .wdata_i(bus_i.wdata),
        .dir_i(port2_direction[P2_W-1:0]),
        .alt_out_i(p2_alt_out_i),
        .pin_i(p2_pin_i),
        .read_o(p2_read),
        .drive_o(p2_drive),
        .drive_en_o(p2_drive_en)
    );

    // RQ5 open-drain port
    pio_port_slice #(.W(P5_W), .OPEN_DRAIN(1'b1)) u_p5 (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_i(bus_i.wr & sel_p5_dat),
        .bit_op_i(bus_i.bit_op),
        .bit_sel_i(bus_i.bit_sel),
        .wdata_i(bus_i.wdata),
        .dir_i(port5_direction[P5_W-1:0]),
        .alt_out_i('0),
        .pin_i(p5_pin_i),
        .read_o(p5_read),
        .drive_o(p5_drive),
        .drive_en_o(p5_drive_en)
    );

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // RQ6 pins only
    // RQ22 unused dir bits read one, unused pull-up bits zero
    assign next_rdata =
        sel_p0_dir ? port0_direction :
        sel_p1_dir ? port1_direction :
        sel_p2_dir ? port2_direction :
        sel_p5_dir ? port5_direction :
        sel_p2_pup ? port2_pullup_enable :
        sel_sh_pup ? shared_pullup_option :
        sel_p0_dat ? 8'(p0_read) :
        sel_p1_dat ? 8'(p1_read) :
        sel_p2_dat ? 8'(p2_read) :
        sel_p5_dat ? 8'(p5_read) :
        sel_p6_dat ? 8'(p6_pin_i) :
        `PIO_UNMAPPED_RD;

    // answer held until the next read, so the cpu may sample late
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= `PIO_UNMAPPED_RD;
        end else if (bus_i.rd) begin
            rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // pull-up enables
    // ----------------------------------------
    // RQ16 bit mapping
    // RQ14 input bits only
    assign next_p0_pullup = {P0_W{shared_pullup_option[`PIO_SH_PUP_P0_BIT]}}
                            & port0_direction[P0_W-1:0];
    // RQ2 whole group
    assign next_p1_pullup = {P1_W{shared_pullup_option[`PIO_SH_PUP_P1_BIT]}}
                            & port1_direction[P1_W-1:0];
    // RQ4 direction ignored
    assign next_p2_pullup = port2_pullup_enable[P2_W-1:0];

    // RQ23 per-pin outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            p0_pullup_o <= '0;
            p1_pullup_o <= '0;
            p2_pullup_o <= '0;
        end else begin
            p0_pullup_o <= next_p0_pullup;
            p1_pullup_o <= next_p1_pullup;
            p2_pullup_o <= next_p2_pullup;
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // RQ7 buffers off
    // RQ9 enable low drives
    // open-drain port drives zero only; oe low means sinking
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            p0_out_o <= '0;
            p0_oe_n_o <= '1;
            p1_out_o <= '0;
            p1_oe_n_o <= '1;
            p2_out_o <= '0;
            p2_oe_n_o <= '1;
            p5_out_o <= '0;
            p5_oe_n_o <= '1;
        end else begin
            p0_out_o <= p0_drive;
            p0_oe_n_o <= ~p0_drive_en;
            p1_out_o <= p1_drive;
            p1_oe_n_o <= ~p1_drive_en;
            p2_out_o <= p2_drive;
            p2_oe_n_o <= ~p2_drive_en;
            p5_out_o <= p5_drive;
            p5_oe_n_o <= ~p5_drive_en;
        end
    end

    // ----------------------------------------
    // external interrupt events
    // ----------------------------------------
    // output bits see the driven level, so a write can fire an event
    assign irq_level =
        (p2_oe_n_o[`PIO_IRQ_HI_BIT:`PIO_IRQ_LO_BIT]
         & p2_pin_i[`PIO_IRQ_HI_BIT:`PIO_IRQ_LO_BIT])
        | (~p2_oe_n_o[`PIO_IRQ_HI_BIT:`PIO_IRQ_LO_BIT]
           & p2_out_o[`PIO_IRQ_HI_BIT:`PIO_IRQ_LO_BIT]);

    // RQ12 level change event
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_level_prev <= '0;
            irq_armed <= 1'b0;
            ext_irq_req_o <= '0;
        end else begin
            irq_level_prev <= irq_level;
            irq_armed <= 1'b1;
            // first cycle after reset only samples, no false event
            ext_irq_req_o <= irq_armed ? (irq_level ^ irq_level_prev) : 3'h0;
        end
    end

endmodule

//--- testbench/pio_top_asserts.sv
// port-level assertions of the port and pull-up control block
module pio_chk #(
    parameter int P0_W = 4,
    parameter int P1_W = 2,
    parameter int P2_W = 6,
    parameter int P5_W = 4,
    parameter int P6_W = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire pio_pkg::pio_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire logic [P0_W-1:0] p0_oe_n_o,
    input wire logic [P0_W-1:0] p0_pullup_o,
    input wire logic [P1_W-1:0] p1_oe_n_o,
    input wire logic [P1_W-1:0] p1_pullup_o,
    input wire logic [P2_W-1:0] p2_pin_i,
    input wire logic [P2_W-1:0] p2_oe_n_o,
    input wire logic [P2_W-1:0] p2_pullup_o,
    input wire logic [P5_W-1:0] p5_out_o,
    input wire logic [P5_W-1:0] p5_oe_n_o,
    input wire logic [P6_W-1:0] p6_pin_i,
    input wire logic [2:0] ext_irq_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // bus decode
    // ----------
    // short names keep the properties on one line
    wire logic [15:0] ad = bus_i.addr;
    wire logic wr = bus_i.wr;
    wire logic wb = bus_i.wr && !bus_i.bit_op;
    wire logic rd = bus_i.rd;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // ----------
    // properties
    // ----------
    property p_rst_off;
        $fell(sys_rst_i) |-> &p0_oe_n_o && &p1_oe_n_o && &p2_oe_n_o && &p5_oe_n_o
            && rdata_o == 8'h00 && ext_irq_req_o == 3'h0;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("outputs active after reset");
    property p_p5_sink;
        p5_out_o == '0;
    endproperty
    a_p5_sink: assert property (p_p5_sink) else $error("open-drain port drives high");
    property p_dir_in;
        (wb && ad == 16'hFF21 && bus_i.wdata[1:0] == 2'h3) |=> ##1 &p1_oe_n_o;
    endproperty
    a_dir_in: assert property (p_dir_in) else $error("input pin still driven");
    // dir writes at the latch write's edge or the edge before it would move the buffers legally
    property p_latch_in;
        !(wr && ad == 16'hFF21) ##1 (wr && ad == 16'hFF01 && !(wr && ad == 16'hFF21)
            && &p1_oe_n_o) |=> ##1 &p1_oe_n_o;
    endproperty
    a_latch_in: assert property (p_latch_in) else $error("latch write drove pin");
    property p_p6_rd;
        (rd && ad == 16'hFF06) |=> rdata_o == {4'h0, $past(p6_pin_i)};
    endproperty
    a_p6_rd: assert property (p_p6_rd) else $error("input port read wrong");
    property p_dir_pad;
        (rd && ad == 16'hFF21) |=> rdata_o[7:2] == 6'h3F;
    endproperty
    a_dir_pad: assert property (p_dir_pad) else $error("unused dir bits not one");
    property p_pu_pad;
        (rd && ad == 16'hFFF7) |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_pu_pad: assert property (p_pu_pad) else $error("unused pull-up bits set");
    property p_p2_pu;
        (wb && ad == 16'hFF32) |=> ##1 p2_pullup_o == $past(bus_i.wdata[5:0], 2);
    endproperty
    a_p2_pu: assert property (p_p2_pu) else $error("pin pull-up not as written");
    property p_grp_pu;
        (p0_pullup_o == '0 || p0_pullup_o == p0_oe_n_o)
            && (p1_pullup_o == '0 || p1_pullup_o == p1_oe_n_o);
    endproperty
    a_grp_pu: assert property (p_grp_pu) else $error("group pull-up on output");
    property p_irq;
        (!$past(sys_rst_i) && $stable(p2_oe_n_o[5:3])) |=>
            ext_irq_req_o == ($past(p2_pin_i[5:3]) ^ $past(p2_pin_i[5:3], 2));
    endproperty
    a_irq: assert property (p_irq) else $error("event pulse mismatch");
endmodule

//--- testbench/pio_pin_model.sv
// board side of one port: external drivers, pull-ups, floating lines
module pio_pin_model #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] oe_n_i,
    input wire logic [W-1:0] pullup_i,
    input wire logic [W-1:0] ext_i,
    input wire logic [W-1:0] ext_en_i,
    output logic [W-1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] float_q = '0;
    // a released line wanders, so a stale level never passes for data
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    // buffer wins, then board, then pull-up
    assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_i)
        | (oe_n_i & ~ext_en_i & (pullup_i | float_q));
endmodule

//--- testbench/port_io_and_pullup_control_tb_top.sv
// self-checking bench of the port and pull-up control block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module port_io_and_pullup_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    pio_pkg::pio_bus_req_t bus_i = '0;
    logic [7:0] rdata_o;
    logic [3:0] p0_pin, p0_out, p0_oe_n, p0_pu, p5_pin, p5_out, p5_oe_n;
    logic [1:0] p1_pin, p1_out, p1_oe_n, p1_pu;
    logic [5:0] p2_pin, p2_out, p2_oe_n, p2_pu;
    logic [2:0] irq;
    logic [3:0] e0 = 4'hA, en0 = 4'hF, e5 = 4'hA, en5 = 4'hF, p6 = 4'h0;
    logic [1:0] e1 = 2'h1, en1 = 2'h3;
    logic [5:0] e2 = 6'h00, en2 = 6'h3F, p2_alt = 6'h00;
    logic [15:0] ra [7] = '{16'hFF20, 16'hFF21, 16'hFF22, 16'hFF25, 16'hFF32, 16'hFFF7, 16'hFF40};
    logic [7:0] rv [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int n = 0;
    int irq_cnt [3] = '{0, 0, 0};

    // ----------
    // clock, timeout, event count
    // ----------
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // the whole run needs about a hundred cycles; a hang is cut at cycle 2000
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 3; i++) begin
            irq_cnt[i] <= irq_cnt[i] + int'(irq[i]);
        end
        if (cyc == 2000) begin
            err_total++;
            end_sim();
        end
    end

    // ----------
    // design, board and checker
    // ----------
    pio_top pio_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .p0_pin_i(p0_pin), .p0_out_o(p0_out), .p0_oe_n_o(p0_oe_n),
        .p0_pullup_o(p0_pu), .p1_pin_i(p1_pin), .p1_out_o(p1_out), .p1_oe_n_o(p1_oe_n),
        .p1_pullup_o(p1_pu), .p2_pin_i(p2_pin), .p2_alt_out_i(p2_alt), .p2_out_o(p2_out),
        .p2_oe_n_o(p2_oe_n), .p2_pullup_o(p2_pu), .p5_pin_i(p5_pin), .p5_out_o(p5_out),
        .p5_oe_n_o(p5_oe_n), .p6_pin_i(p6), .ext_irq_req_o(irq));
    pio_pin_model #(.W(4)) m0 (.clk_i(clk_i), .out_i(p0_out), .oe_n_i(p0_oe_n),
        .pullup_i(p0_pu), .ext_i(e0), .ext_en_i(en0), .pin_o(p0_pin));
    pio_pin_model #(.W(2)) m1 (.clk_i(clk_i), .out_i(p1_out), .oe_n_i(p1_oe_n),
        .pullup_i(p1_pu), .ext_i(e1), .ext_en_i(en1), .pin_o(p1_pin));
    pio_pin_model #(.W(6)) m2 (.clk_i(clk_i), .out_i(p2_out), .oe_n_i(p2_oe_n),
        .pullup_i(p2_pu), .ext_i(e2), .ext_en_i(en2), .pin_o(p2_pin));
    pio_pin_model #(.W(4)) m5 (.clk_i(clk_i), .out_i(p5_out), .oe_n_i(p5_oe_n),
        .pullup_i(4'h0), .ext_i(e5), .ext_en_i(en5), .pin_o(p5_pin));

    // ----------
    // bus tasks
    // ----------
    // one access per call, held for exactly the edge that takes it
    task automatic op(input logic [15:0] a, input logic w, input logic b,
                      input logic [2:0] s, input logic [7:0] d);
        @(posedge clk_i);
        bus_i <= '{addr: a, wr: w, rd: !w, bit_op: b, bit_sel: s, wdata: d};
        @(posedge clk_i);
        bus_i <= '0;
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        op(a, 1'b1, 1'b0, 3'h0, d);
    endtask
    task automatic wrb(input logic [15:0] a, input logic [2:0] s, input logic v);
        op(a, 1'b1, 1'b1, s, {7'h00, v});
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        op(a, 1'b0, 1'b0, 3'h0, 8'h00);
        `CHK(rdata_o, e)
    endtask
    // pin outputs trail the registers by one edge
    task automatic hold();
        @(posedge clk_i);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------
    // tests
    // ----------
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK({p0_oe_n, p1_oe_n, p2_oe_n, p5_oe_n}, 16'hFFFF)
        foreach (ra[i]) begin
            rd(ra[i], rv[i]);
        end
        $display("test reset done");
        wr(16'hFF21, 8'h00);
        rd(16'hFF21, 8'hFC);
        wrb(16'hFF20, 3'h2, 1'b0);
        rd(16'hFF20, 8'hFB);
        hold();
        `CHK(p0_oe_n, 4'hB)
        wr(16'hFF00, 8'h04);
        rd(16'hFF00, 8'h0E);
        wr(16'hFF01, 8'h02);
        hold();
        `CHK({p0_out, p1_out}, 6'h12)
        rd(16'hFF01, 8'h02);
        wr(16'hFF21, 8'hFF);
        wr(16'hFF01, 8'h03);
        hold();
        `CHK(p1_oe_n, 2'h3)
        rd(16'hFF01, 8'h01);
        wr(16'hFF21, 8'h00);
        hold();
        `CHK(p1_out, 2'h3)
        $display("test latch done");
        wr(16'hFFF7, 8'hFF);
        rd(16'hFFF7, 8'h03);
        hold();
        `CHK({p0_pu, p1_pu}, 6'h2C)
        wrb(16'hFF21, 3'h0, 1'b1);
        hold();
        `CHK(p1_pu, 2'h1)
        wrb(16'hFFF7, 3'h1, 1'b0);
        rd(16'hFFF7, 8'h01);
        hold();
        `CHK({p0_pu, p1_pu}, 6'h2C)
        $display("test group pull-up done");
        wr(16'hFF22, 8'hC0);
        rd(16'hFF22, 8'hC0);
        wr(16'hFF32, 8'hFF);
        rd(16'hFF32, 8'h3F);
        hold();
        `CHK(p2_pu, 6'h3F)
        wrb(16'hFF32, 3'h5, 1'b0);
        rd(16'hFF32, 8'h1F);
        hold();
        `CHK(p2_pu, 6'h1F)
        $display("test pin pull-up done");
        // timer output: direction and latch both zero
        // pulses counted here; a real cpu masks them first
        n = irq_cnt[1];
        wrb(16'hFF02, 3'h4, 1'b1);
        repeat (3) hold();
        `CHK(irq_cnt[1] - n, 1)
        @(posedge clk_i);
        p2_alt <= 6'h01;
        repeat (2) hold();
        `CHK(p2_out[0], 1'b1)
        // event input: direction one, latch ignored
        wrb(16'hFF22, 3'h3, 1'b1);
        n = irq_cnt[0];
        @(posedge clk_i);
        e2 <= 6'h08;
        repeat (3) hold();
        `CHK(irq_cnt[0] - n, 1)
        $display("test events done");
        wr(16'hFF05, 8'h05);
        wr(16'hFF25, 8'hF0);
        hold();
        `CHK({p5_oe_n, p5_out}, 8'h50)
        // open-drain port read three times in a row
        repeat (3) rd(16'hFF05, 8'h05);
        wr(16'hFF25, 8'hFF);
        rd(16'hFF05, 8'h0A);
        @(posedge clk_i);
        p6 <= 4'h6;
        wr(16'hFF06, 8'h55);
        rd(16'hFF06, 8'h06);
        $display("test open-drain and input port done");
        end_sim();
    end
endmodule

bind pio_top pio_chk #(.P0_W(P0_W), .P1_W(P1_W), .P2_W(P2_W), .P5_W(P5_W), .P6_W(P6_W))
    pio_chk_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .p0_oe_n_o(p0_oe_n_o), .p0_pullup_o(p0_pullup_o), .p1_oe_n_o(p1_oe_n_o),
    .p1_pullup_o(p1_pullup_o), .p2_pin_i(p2_pin_i), .p2_oe_n_o(p2_oe_n_o),
    .p2_pullup_o(p2_pullup_o), .p5_out_o(p5_out_o), .p5_oe_n_o(p5_oe_n_o),
    .p6_pin_i(p6_pin_i), .ext_irq_req_o(ext_irq_req_o));
